// ==== rtl/hul_pkg.sv ====
package hul_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_SLOT = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h10;
    localparam int CTRL_CTS_EN = 0;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [7:0] SLOT_RST = 8'h00;
    localparam logic [3:0] MASK_RST = 4'h0;
    // Interrupt bits
    localparam int IRQ_UP = 0;
    localparam int IRQ_DOWN = 1;
    localparam int IRQ_CLAIM = 2;
    localparam int IRQ_TMO = 3;
    localparam int IRQ_W = 4;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int XID_GAP_MS = 70;
    localparam int XID_GAP_CYC = XID_GAP_MS * CLK_MHZ * 1000;
    localparam int INIT_CYC = 3;
    // ----------------------------------------
    // Frames and states
    // ----------------------------------------
    typedef enum logic [2:0] {
        FR_XID = 3'h0, FR_BCAST = 3'h1, FR_SNRM = 3'h2, FR_IAS_OPEN = 3'h3,
        FR_IAS_QRY = 3'h4, FR_DATA_OPEN = 3'h5, FR_DISC = 3'h6, FR_OTHER = 3'h7
    } hul_frame_t;
    typedef enum logic [2:0] {
        RS_XID = 3'h0, RS_UA = 3'h1, RS_IAS_CONF = 3'h2, RS_IAS_ANS = 3'h3,
        RS_DATA_CONF = 3'h4, RS_SHUT = 3'h5
    } hul_resp_t;
    typedef enum logic [2:0] {
        ST_NDM = 3'h0, ST_CLAIMED = 3'h1, ST_CONN = 3'h3, ST_IAS = 3'h2,
        ST_NRM = 3'h6
    } hul_state_t;
endpackage

// ==== rtl/hul_link.sv ====
// What this block does
// - Three enabled cycles after reset the block samples request and terminal-ready; only request low with terminal-ready high enters identity programming.
// - On the plain variant the terminal-ready input is ignored once initialisation has finished.
// - On the forwarding variant the terminal-ready level is sent to the primary as a status bit, low meaning ready.
// - On the plain variant data-set-ready is 1 once initialised and 0 before.
// - On the forwarding variant data-set-ready is low while a link exists and high otherwise, generated locally.
// - On the plain variant carrier-detect is driven low while a link exists and high without one.
// - On the forwarding variant carrier-detect is a host input whose level is reported to the primary.
// - On the plain variant the ring output is held high with no other function.
// - On the forwarding variant ring is a host input whose level is reported to the primary.
// - In discovery the block stays silent, answers one XID in its claimed slot, then ignores later XIDs and the broadcast.
// - An SNRM with a connection address is answered by a UA carrying that address.
// - After IAS channel confirm, IAS answers and data channel confirm the block enters normal response mode and drives link low.
// - The link output stays low while the link is open and goes inactive on shutdown.
// - Clear-to-send is low when the host may transmit and high when it must not.
module hul_link import hul_pkg::*; #(
    parameter bit FWD_VARIANT = 1'b0,
    parameter int TMO_CYC = XID_GAP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rts_n_i,
    input wire logic dtr_n_i,
    input wire logic cd_n_i,
    input wire logic ri_n_i,
    output logic cts_n_o,
    output logic dsr_o,
    output logic cd_n_o,
    output logic ri_n_o,
    output logic link_n_o,
    output logic host_tx_ok_o,
    output logic id_prog_o,
    input wire logic frm_valid_i,
    input wire hul_frame_t frm_kind_i,
    input wire logic [7:0] frm_slot_i,
    input wire logic [7:0] frm_addr_i,
    output logic rsp_valid_o,
    output hul_resp_t rsp_kind_o,
    output logic [7:0] rsp_addr_o,
    output logic [2:0] fwd_stat_o,
    output logic irq_o
);
    // ----------------------------------------
    // Host pin synchronisers
    // ----------------------------------------
    logic [3:0] sy1_ff, sy2_ff, nxt_sy1, nxt_sy2;
    logic rts_s, dtr_s, cd_s, ri_s;
    always_comb begin
        nxt_sy1 = {ri_n_i, cd_n_i, dtr_n_i, rts_n_i};
        nxt_sy2 = sy1_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sy1_ff <= 4'hF;
            sy2_ff <= 4'hF;
        end else if (ce_i) begin
            sy1_ff <= nxt_sy1;
            sy2_ff <= nxt_sy2;
        end
    end

    assign {ri_s, cd_s, dtr_s, rts_s} = sy2_ff;

    // ----------------------------------------
    // Power-up strap sampling
    // ----------------------------------------
    logic [1:0] icnt_ff, nxt_icnt;
    logic init_ff, nxt_init, idp_ff, nxt_idp;
    always_comb begin
        nxt_icnt = icnt_ff;
        nxt_init = init_ff;
        nxt_idp = idp_ff;
        if (!init_ff) begin
            if (icnt_ff == 2'(INIT_CYC - 1)) begin
                nxt_init = 1'b1;
                nxt_idp = ~rts_s & dtr_s;
            end else begin
                nxt_icnt = icnt_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            icnt_ff <= 2'h0;
            init_ff <= 1'b0;
            idp_ff <= 1'b0;
        end else if (ce_i) begin
            icnt_ff <= nxt_icnt;
            init_ff <= nxt_init;
            idp_ff <= nxt_idp;
        end
    end

    // ----------------------------------------
    // Discovery and connection
    // ----------------------------------------
    hul_state_t st_ff, nxt_st;
    logic [31:0] tmo_ff, nxt_tmo;
    logic rv_ff, nxt_rv;
    hul_resp_t rk_ff, nxt_rk;
    logic [7:0] ra_ff, nxt_ra;
    logic [7:0] slot_ff;
    logic [IRQ_W-1:0] ev;
    logic go;
    // No frames are handled during identity programming or before init
    assign go = frm_valid_i & init_ff & ~idp_ff;

    always_comb begin
        nxt_st = st_ff;
        nxt_tmo = tmo_ff;
        nxt_rv = 1'b0;
        nxt_rk = rk_ff;
        nxt_ra = ra_ff;
        ev = '0;
        case (st_ff)
            ST_NDM: begin
                if (go && frm_kind_i == FR_XID && frm_slot_i == slot_ff) begin
                    nxt_rv = 1'b1;
                    nxt_rk = RS_XID;
                    nxt_st = ST_CLAIMED;
                    nxt_tmo = 32'h0;
                    ev[IRQ_CLAIM] = 1'b1;
                end
            end
            ST_CLAIMED: begin
                // Later XIDs and the broadcast fall through silently
                nxt_tmo = tmo_ff + 32'h1;
                if (go && frm_kind_i == FR_SNRM) begin
                    nxt_rv = 1'b1;
                    nxt_rk = RS_UA;
                    nxt_ra = frm_addr_i;
                    nxt_st = ST_CONN;
                end else if (tmo_ff >= 32'(TMO_CYC)) begin
                    nxt_st = ST_NDM;
                    ev[IRQ_TMO] = 1'b1;
                end
            end
            ST_CONN: begin
                if (go && frm_kind_i == FR_IAS_OPEN) begin
                    nxt_rv = 1'b1;
                    nxt_rk = RS_IAS_CONF;
                    nxt_st = ST_IAS;
                end
            end
            ST_IAS: begin
                if (go && frm_kind_i == FR_IAS_QRY) begin
                    nxt_rv = 1'b1;
                    nxt_rk = RS_IAS_ANS;
                end else if (go && frm_kind_i == FR_DATA_OPEN) begin
                    nxt_rv = 1'b1;
                    nxt_rk = RS_DATA_CONF;
                    nxt_st = ST_NRM;
                    ev[IRQ_UP] = 1'b1;
                end
            end
            ST_NRM: begin
                if (go && frm_kind_i == FR_DISC) begin
                    nxt_rv = 1'b1;
                    nxt_rk = RS_SHUT;
                    nxt_st = ST_NDM;
                    ev[IRQ_DOWN] = 1'b1;
                end
            end
            default: nxt_st = ST_NDM;
        endcase
        if (go && frm_kind_i == FR_DISC && st_ff != ST_NRM && st_ff != ST_NDM) begin
            nxt_st = ST_NDM;
        end
        if (!ce_i) begin
            ev = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= ST_NDM;
            tmo_ff <= 32'h0;
            rv_ff <= 1'b0;
            rk_ff <= RS_XID;
            ra_ff <= 8'h00;
        end else if (ce_i) begin
            st_ff <= nxt_st;
            tmo_ff <= nxt_tmo;
            rv_ff <= nxt_rv;
            rk_ff <= nxt_rk;
            ra_ff <= nxt_ra;
        end
    end

    // ----------------------------------------
    // Host-side lines
    // ----------------------------------------
    logic link;
    logic [1:0] ctrl_ff;
    assign link = (st_ff == ST_NRM);
    assign link_n_o = ~link;
    assign cts_n_o = ~(link & ctrl_ff[CTRL_CTS_EN] & ~idp_ff);
    assign host_tx_ok_o = link & ~rts_s;
    assign id_prog_o = idp_ff;
    assign rsp_valid_o = rv_ff;
    assign rsp_kind_o = rk_ff;
    assign rsp_addr_o = ra_ff;

    generate
        if (FWD_VARIANT) begin : g_fwd
            assign dsr_o = ~link;
            assign cd_n_o = 1'b1;
            assign ri_n_o = 1'b1;
            // Levels forwarded as received: low means ready/carrier/ring
            assign fwd_stat_o = {ri_s, cd_s, dtr_s};
        end else begin : g_plain
            assign dsr_o = init_ff;
            assign cd_n_o = ~link;
            assign ri_n_o = 1'b1;
            // Terminal-ready plays no part after the strap sample
            assign fwd_stat_o = 3'h7;
        end
    endgenerate

    // ----------------------------------------
    // Wishbone registers and interrupts
    // ----------------------------------------
    logic ack_ff, nxt_ack;
    logic [31:0] dat_ff, nxt_dat;
    logic [1:0] nxt_ctrl;
    logic [7:0] nxt_slot;
    logic [IRQ_W-1:0] ist_ff, nxt_ist, msk_ff, nxt_msk;
    logic req, wr, rd;

    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign rd = req & ~wb_we_i;
    always_comb begin
        nxt_ack = req;
        nxt_dat = 32'h0;
        nxt_ctrl = ctrl_ff;
        nxt_slot = slot_ff;
        nxt_msk = msk_ff;
        nxt_ist = ist_ff;
        if (wr) begin
            case (wb_adr_i)
                ADR_CTRL: nxt_ctrl = wb_dat_i[1:0];
                ADR_SLOT: nxt_slot = wb_dat_i[7:0];
                ADR_IRQ_MASK: nxt_msk = wb_dat_i[IRQ_W-1:0];
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        if (rd) begin
            case (wb_adr_i)
                ADR_CTRL: nxt_dat = {30'h0, ctrl_ff};
                ADR_SLOT: nxt_dat = {24'h0, slot_ff};
                ADR_STAT: nxt_dat = {22'h0, sy2_ff, st_ff, idp_ff, init_ff, link};
                ADR_IRQ_STAT: begin
                    nxt_dat = {28'h0, ist_ff};
                    nxt_ist = '0;
                end
                ADR_IRQ_MASK: nxt_dat = {28'h0, msk_ff};
                default: nxt_dat = 32'h0;
            endcase
        end
        // A new event wins over the read clear
        nxt_ist = nxt_ist | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
            ctrl_ff <= CTRL_RST;
            slot_ff <= SLOT_RST;
            msk_ff <= MASK_RST;
            ist_ff <= '0;
        end else if (ce_i) begin
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
            ctrl_ff <= nxt_ctrl;
            slot_ff <= nxt_slot;
            msk_ff <= nxt_msk;
            ist_ff <= nxt_ist;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign irq_o = |(ist_ff & msk_ff);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_TX_OK: assert property (host_tx_ok_o |-> !rts_s && link)
        else $error("host send permitted while request line high");
    AST_STRAP: assert property ($rose(init_ff) |-> idp_ff == (!$past(rts_s) && $past(dtr_s)))
        else $error("identity programming strap sampled wrongly");
    AST_NO_FWD: assert property (!FWD_VARIANT |-> fwd_stat_o == 3'h7)
        else $error("terminal-ready leaked on plain variant");
    AST_FWD: assert property (FWD_VARIANT && ce_i |=> fwd_stat_o[0] == $past(sy1_ff[1]))
        else $error("forwarded terminal-ready level wrong");
    AST_DSR: assert property (!FWD_VARIANT |-> dsr_o == init_ff)
        else $error("ready output does not follow init");
    AST_DSR_LINK: assert property (FWD_VARIANT |-> dsr_o == (st_ff != ST_NRM))
        else $error("set-ready does not follow link");
    AST_CD: assert property (!FWD_VARIANT |-> cd_n_o == link_n_o)
        else $error("carrier output does not follow link");
    AST_RI: assert property (!FWD_VARIANT |-> ri_n_o)
        else $error("ring output not high");
    AST_CLAIM: assert property (st_ff == ST_CLAIMED && go && frm_kind_i != FR_SNRM |=> !rv_ff)
        else $error("answer given after slot claimed");
    AST_UA: assert property (ce_i && st_ff == ST_CLAIMED && go && frm_kind_i == FR_SNRM
        |=> rv_ff && rk_ff == RS_UA && ra_ff == $past(frm_addr_i))
        else $error("UA missing or wrongly addressed");
    AST_UP: assert property ($fell(link_n_o) |-> $past(st_ff) == ST_IAS && rk_ff == RS_DATA_CONF)
        else $error("link up without data channel confirm");
    AST_DOWN: assert property ($rose(link_n_o) |-> rk_ff == RS_SHUT && rv_ff)
        else $error("link dropped without shutdown");
    AST_CTS: assert property (!cts_n_o |-> link && !idp_ff)
        else $error("send cleared without link");
    AST_SYNC: assert property (ce_i |=> sy2_ff == $past(sy1_ff))
        else $error("synchroniser stage skipped");

    COV_LINK: cover property ($fell(link_n_o));
    COV_SHUT: cover property ($rose(link_n_o));
    COV_TMO: cover property (ev[IRQ_TMO]);
    COV_IRQ: cover property ($rose(irq_o));
endmodule

// ==== dv/hul_host_model.sv ====
module hul_host_model (
    input wire logic cts_n_i,
    output logic rts_n_o,
    output logic dtr_n_o,
    output logic cd_n_o,
    output logic ri_n_o,
    output logic tx_go_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Host pin levels
    // ----------------------------------------
    logic tx_want;
    // Idle host: not requesting to send, terminal ready, no carrier, no ring
    initial begin
        rts_n_o = 1'b1;
        dtr_n_o = 1'b0;
        cd_n_o = 1'b1;
        ri_n_o = 1'b1;
        tx_want = 1'b0;
    end
    task automatic set_pins(input logic rts, input logic dtr, input logic cd, input logic ri);
        rts_n_o <= rts;
        dtr_n_o <= dtr;
        cd_n_o <= cd;
        ri_n_o <= ri;
    endtask
    task automatic want_tx(input logic w);
        tx_want <= w;
    endtask
    // Sends only on a solid low, so an unknown line never lets data through
    assign tx_go_o = tx_want && (cts_n_i === 1'b0);
endmodule

// ==== dv/host_uart_ir_link_signals_tb_top.sv ====
module host_uart_ir_link_signals_tb_top import hul_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'hF;
    logic fvalid = 1'b0;
    hul_frame_t fkind = FR_OTHER;
    logic [7:0] fslot = 8'h00;
    logic [7:0] faddr = 8'h00;
    logic rts_n, dtr_n, cd_n, ri_n, tx_go, ack, cts_n, dsr, cdo_n, rio_n, link_n;
    logic tx_ok, id_prog, rsp_v, irq, dsr2;
    logic [31:0] rdat, rd;
    hul_resp_t rsp_k;
    logic [7:0] rsp_a;
    logic [2:0] fwd, fwd2;
    int miscompares = 0;
    int tests_run = 0;
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    hul_host_model host (.cts_n_i(cts_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .cd_n_o(cd_n),
        .ri_n_o(ri_n), .tx_go_o(tx_go));
    hul_link #(.FWD_VARIANT(1'b0), .TMO_CYC(5000)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .rts_n_i(rts_n),
        .dtr_n_i(dtr_n), .cd_n_i(cd_n), .ri_n_i(ri_n), .cts_n_o(cts_n), .dsr_o(dsr),
        .cd_n_o(cdo_n), .ri_n_o(rio_n), .link_n_o(link_n), .host_tx_ok_o(tx_ok),
        .id_prog_o(id_prog), .frm_valid_i(fvalid), .frm_kind_i(fkind), .frm_slot_i(fslot),
        .frm_addr_i(faddr), .rsp_valid_o(rsp_v), .rsp_kind_o(rsp_k), .rsp_addr_o(rsp_a),
        .fwd_stat_o(fwd), .irq_o(irq));
    // Forwarding variant shares every input so both see the same session
    hul_link #(.FWD_VARIANT(1'b1), .TMO_CYC(5000)) uut2 (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(), .wb_ack_o(), .rts_n_i(rts_n),
        .dtr_n_i(dtr_n), .cd_n_i(cd_n), .ri_n_i(ri_n), .cts_n_o(), .dsr_o(dsr2),
        .cd_n_o(), .ri_n_o(), .link_n_o(), .host_tx_ok_o(), .id_prog_o(),
        .frm_valid_i(fvalid), .frm_kind_i(fkind), .frm_slot_i(fslot), .frm_addr_i(faddr),
        .rsp_valid_o(), .rsp_kind_o(), .rsp_addr_o(), .fwd_stat_o(fwd2), .irq_o());
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] t=%0t %s got %0h exp %0h", $time, s, got, exp);
            miscompares++;
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        // A missing ack is left to the watchdog
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input string s);
        wb(1'b0, a, 32'h0);
        chk(rd, e, s);
    endtask
    task automatic frm(input hul_frame_t k, input logic [7:0] sl, input logic [7:0] a,
        input logic ev, input hul_resp_t ek);
        fvalid <= 1'b1;
        fkind <= k;
        fslot <= sl;
        faddr <= a;
        @(posedge clk_i);
        fvalid <= 1'b0;
        @(posedge clk_i);
        chk(rsp_v, ev, "rsp valid");
        if (ev) chk(rsp_k, ek, "rsp kind");
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(6);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        tick(2);
        chk(dsr, 1'b0, "dsr in reset");
        chk(dsr2, 1'b1, "dsr2 in reset");
        rst_i <= 1'b0;
        tick(6);
        chk(dsr, 1'b1, "dsr init");
        chk(cdo_n, 1'b1, "cd no link");
        chk(rio_n, 1'b1, "ring");
        chk(cts_n, 1'b1, "cts no link");
        chk(id_prog, 1'b0, "idp");
        rdx(ADR_CTRL, 32'h0, "ctrl");
        rdx(ADR_SLOT, 32'h0, "slot");
        rdx(ADR_IRQ_MASK, 32'h0, "mask");
        wb(1'b1, 8'h40, 32'hFFFFFFFF);
        rdx(8'h40, 32'h0, "unmapped");
        wb(1'b1, ADR_SLOT, 32'h5);
        wb(1'b1, ADR_IRQ_MASK, 32'hF);
        wb(1'b1, ADR_CTRL, 32'h1);
        rdx(ADR_SLOT, 32'h5, "slot wr");
        // Lane 0 disabled: the write is acked but must not land
        sel <= 4'hE;
        wb(1'b1, ADR_SLOT, 32'h77);
        sel <= 4'hF;
        rdx(ADR_SLOT, 32'h5, "sel0 ignored");
        host.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
        tick(2);
        chk(fwd2, 3'b110, "sync depth");
        tick(1);
        chk(fwd2, 3'b001, "fwd levels");
        chk(fwd, 3'b111, "plain fwd");
        chk(id_prog, 1'b0, "dtr ignored");
        host.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
        tick(3);
        frm(FR_XID, 8'h04, 8'h00, 1'b0, RS_XID);
        frm(FR_BCAST, 8'h00, 8'h00, 1'b0, RS_XID);
        frm(FR_XID, 8'h05, 8'h00, 1'b1, RS_XID);
        frm(FR_XID, 8'h05, 8'h00, 1'b0, RS_XID);
        frm(FR_XID, 8'h06, 8'h00, 1'b0, RS_XID);
        frm(FR_BCAST, 8'h00, 8'h00, 1'b0, RS_XID);
        chk(irq, 1'b1, "irq claim");
        frm(FR_SNRM, 8'h00, 8'hA5, 1'b1, RS_UA);
        chk(rsp_a, 8'hA5, "ua addr");
        frm(FR_IAS_OPEN, 8'h00, 8'h00, 1'b1, RS_IAS_CONF);
        chk(link_n, 1'b1, "link early");
        frm(FR_IAS_QRY, 8'h00, 8'h00, 1'b1, RS_IAS_ANS);
        frm(FR_IAS_QRY, 8'h00, 8'h00, 1'b1, RS_IAS_ANS);
        chk(link_n, 1'b1, "link early");
        frm(FR_DATA_OPEN, 8'h00, 8'h00, 1'b1, RS_DATA_CONF);
        chk(link_n, 1'b0, "link up");
        chk(cdo_n, 1'b0, "cd link");
        chk(dsr2, 1'b0, "dsr2 link");
        chk(cts_n, 1'b0, "cts link");
        host.want_tx(1'b1);
        host.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
        tick(3);
        chk(tx_ok, 1'b1, "tx ok");
        chk(tx_go, 1'b1, "host sends");
        host.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
        tick(3);
        chk(tx_ok, 1'b0, "tx hold");
        // Clock enable low: a shutdown frame must be ignored
        ce <= 1'b0;
        frm(FR_DISC, 8'h00, 8'h00, 1'b0, RS_SHUT);
        chk(link_n, 1'b0, "ce freeze");
        ce <= 1'b1;
        tick(20);
        chk(link_n, 1'b0, "link holds");
        rdx(ADR_IRQ_STAT, 32'h5, "irq stat");
        rdx(ADR_IRQ_STAT, 32'h0, "irq clr");
        chk(irq, 1'b0, "irq low");
        wb(1'b1, ADR_IRQ_MASK, 32'h0);
        frm(FR_DISC, 8'h00, 8'h00, 1'b1, RS_SHUT);
        chk(link_n, 1'b1, "link down");
        chk(cdo_n, 1'b1, "cd down");
        chk(dsr2, 1'b1, "dsr2 down");
        chk(cts_n, 1'b1, "cts down");
        chk(tx_go, 1'b0, "host holds");
        chk(irq, 1'b0, "irq masked");
        rdx(ADR_IRQ_STAT, 32'h2, "irq down");
        // Strap combinations: {dtr, rts}; only rts low with dtr high programs
        for (int i = 0; i < 4; i++) begin
            host.set_pins(i[0], i[1], 1'b1, 1'b1);
            do_reset();
            chk(id_prog, !i[0] && i[1], "strap");
            if (i == 2) frm(FR_XID, 8'h00, 8'h00, 1'b0, RS_XID);
        end
        conclude();
    end
    initial begin
        tick(20000);
        miscompares++;
        conclude();
    end
endmodule
